// File: tb/rxtun_regs_bench.sv
`timescale 1ns/1ps
module rxtun_regs_bench
   import rxtun_pkg::*;
;
   // ****************************************************************
   // Stimulus, table and bench model
   // ****************************************************************
   typedef struct packed {
      logic [RXTUN_ADDR_W-1:0] a; // Byte address
      logic [7:0] d; // Data written
      logic [7:0] e; // Readback expected
   } rxtun_row_t;
   localparam rxtun_row_t ROWS [12] = '{
      '{RXTUN_ADDR_THRESHOLD, 8'hA5, 8'hA5}, '{RXTUN_ADDR_THRESHOLD, 8'h5A, 8'h5A},
      '{RXTUN_ADDR_INPUT_MODE, 8'h80, 8'h80}, '{RXTUN_ADDR_INPUT_MODE, 8'h51, 8'h51},
      '{RXTUN_ADDR_INPUT_MODE, 8'h2E, 8'h22}, '{RXTUN_ADDR_INPUT_MODE, 8'hFF, 8'hF3},
      '{RXTUN_ADDR_ANALOG, 8'h3F, 8'h0F}, '{RXTUN_ADDR_ANALOG, 8'h36, 8'h06},
      '{RXTUN_ADDR_ANALOG, 8'h09, 8'h09}, '{RXTUN_ADDR_ANALOG, 8'h00, 8'h00},
      '{10'h0E8, 8'hFF, 8'h00}, '{RXTUN_ADDR_THRESHOLD, 8'h0F, 8'h0F}};
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [RXTUN_ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] min_lvl, phase_lvl, src_hot, hp_sel, gain_sel;
   logic pin_mode, low_power_card_detect, coll_en;
   logic [1:0] src_sel, coll_thr, trim;
   logic [7:0] thr = '0; // Expected register contents
   logic [7:0] mode = '0;
   logic [7:0] ana = '0;
   logic [31:0] rd; // Last read data
   int polls; // Edges waited for waitrequest low on the last bus cycle
   int failures = 0;
   int comparisons = 0;

   rxtun_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
      .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
      .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .min_reception_level_o(min_lvl),
      .phase_detector_min_level_o(phase_lvl), .receive_input_pin_o(pin_mode), .low_power_card_detect_o(low_power_card_detect),
      .signal_source_select_o(src_sel), .source_onehot_o(src_hot), .collision_detect_en_o(coll_en),
      .collision_threshold_o(coll_thr), .midrail_trim_o(trim), .highpass_select_o(hp_sel),
      .gain_select_o(gain_sel));

   // Free-running 250 MHz clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One Avalon cycle; held until waitrequest is sampled low
   task automatic bus_cycle(input logic wr, input logic [RXTUN_ADDR_W-1:0] a, input logic [7:0] d,
         input logic [3:0] be);
      @(posedge clk_i);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'hFF_FFFF, d}; // Upper lanes must be ignored
      avs_byteenable <= be;
      polls = 0;
      do begin
         @(posedge clk_i);
         polls++;
      end while (avs_waitrequest !== 1'b0 && polls < 50);
      if (polls >= 50) failures++; // Hung slave
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus_cycle

   // Every decoded output against the bench copy of the registers
   task automatic check_fields;
      check(min_lvl, thr[7:4]);
      check(phase_lvl, thr[3:0]);
      check(pin_mode, mode[7]);
      check(low_power_card_detect, mode[6]);
      check(src_sel, mode[5:4]);
      check(src_hot, 4'h1 << mode[5:4]);
      check(coll_thr, mode[1:0]);
      check(coll_en, mode[1:0] != 2'h3);
      check(trim, ana[7:6]);
      check(hp_sel, 4'h1 << ana[3:2]);
      check(gain_sel, 4'h1 << ana[1:0]);
   endtask : check_fields

   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      check_fields();
      check(avs_waitrequest, 1'b1);
      $display("Reset test done");
      // Table rows: write, read back at once, then let the outputs settle
      for (int i = 0; i < 12; i++) begin
         bus_cycle(1'b1, ROWS[i].a, ROWS[i].d, 4'hF);
         check(polls, 2);
         bus_cycle(1'b0, ROWS[i].a, 8'h00, 4'hF);
         check(rd, {24'h00_0000, ROWS[i].e});
         if (ROWS[i].a == RXTUN_ADDR_THRESHOLD) thr = ROWS[i].e;
         if (ROWS[i].a == RXTUN_ADDR_INPUT_MODE) mode = ROWS[i].e;
         if (ROWS[i].a == RXTUN_ADDR_ANALOG) ana = ROWS[i].e;
         repeat (3) @(posedge clk_i);
         check_fields();
         $display("Row %0d done", i);
      end
      // Lane 0 disabled: write must not land
      bus_cycle(1'b1, RXTUN_ADDR_THRESHOLD, 8'h33, 4'hE);
      bus_cycle(1'b0, RXTUN_ADDR_THRESHOLD, 8'h00, 4'hF);
      check(rd, 32'h0000_000F);
      $display("Byte enable test done");
      // Reset in mid-run clears every field
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      thr = '0;
      mode = '0;
      ana = '0;
      check_fields();
      check(avs_waitrequest, 1'b1);
      reset_i <= 1'b0;
      bus_cycle(1'b0, RXTUN_ADDR_INPUT_MODE, 8'h00, 4'hF);
      check(rd, 32'h0000_0000);
      $display("Second reset test done");
      end_of_test();
   end

   // Watchdog, far beyond the roughly 140 cycles the run needs
   initial begin
      repeat (5000) @(posedge clk_i);
      failures++;
      end_of_test();
   end
endmodule : rxtun_regs_bench

// File: verilog/rxtun_onehot.sv
`timescale 1ns/1ps
// ****************************************************************
// Registered 2-to-4 decoder for the analog and source selects
// ****************************************************************
module rxtun_onehot
   import rxtun_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [1:0] code_i,
   output logic [3:0] sel_o
);
   logic [3:0] next_sel; // Decoded one-hot value

   // One bit per code, via a generate loop
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_dec
         always_comb begin
            next_sel[g] = (code_i == 2'(g));
         end
      end
   endgenerate

   // Register the decoded select
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_o <= 4'h1;
      end else begin
         sel_o <= next_sel;
      end
   end
endmodule : rxtun_onehot

// File: verilog/rxtun_pkg.sv
package rxtun_pkg;
   // ****************************************************************
   // Register indices (printed offsets are not multiples of four)
   // ****************************************************************
   localparam logic [7:0] RXTUN_IDX_THRESHOLD = 8'h37;
   localparam logic [7:0] RXTUN_IDX_INPUT_MODE = 8'h38;
   localparam logic [7:0] RXTUN_IDX_ANALOG = 8'h39;
   // Byte address is four times the index
   localparam int RXTUN_ADDR_W = 10;
   localparam logic [9:0] RXTUN_ADDR_THRESHOLD = 10'h0DC;
   localparam logic [9:0] RXTUN_ADDR_INPUT_MODE = 10'h0E0;
   localparam logic [9:0] RXTUN_ADDR_ANALOG = 10'h0E4;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int RXTUN_MIN_LEVEL_LSB = 4;
   localparam int RXTUN_PHASE_LEVEL_LSB = 0;
   localparam int RXTUN_INPUT_PIN_BIT = 7;
   localparam int RXTUN_CONV_MODE_BIT = 6;
   localparam int RXTUN_SIG_SRC_LSB = 4;
   localparam int RXTUN_COLL_LSB = 0;
   localparam int RXTUN_TRIM_LSB = 6;
   localparam int RXTUN_HPCF_LSB = 2;
   localparam int RXTUN_GAIN_LSB = 0;

   // Writable bit masks; reserved bits stay zero
   localparam logic [7:0] RXTUN_MASK_THRESHOLD = 8'hFF;
   localparam logic [7:0] RXTUN_MASK_INPUT_MODE = 8'hF3;
   localparam logic [7:0] RXTUN_MASK_ANALOG = 8'hCF;

   // ****************************************************************
   // Reset values (none documented, chosen as zero)
   // ****************************************************************
   localparam logic [7:0] RXTUN_RST_THRESHOLD = 8'h00;
   localparam logic [7:0] RXTUN_RST_INPUT_MODE = 8'h00;
   localparam logic [7:0] RXTUN_RST_ANALOG = 8'h00;

   // ****************************************************************
   // Encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      RXTUN_SRC_IDLE = 2'b00,
      RXTUN_SRC_ANALOG = 2'b01,
      RXTUN_SRC_ENVELOPE = 2'b10,
      RXTUN_SRC_EXTERNAL = 2'b11
   } rxtun_src_t;

   typedef enum logic [1:0] {
      RXTUN_COLL_EIGHTH = 2'b00,
      RXTUN_COLL_QUARTER = 2'b01,
      RXTUN_COLL_HALF = 2'b10,
      RXTUN_COLL_OFF = 2'b11
   } rxtun_coll_t;
endpackage : rxtun_pkg

// File: verilog/rxtun_regs.sv
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rxtun_regs
   import rxtun_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   // Avalon-MM slave
   input wire logic [RXTUN_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Decoded fields to the receiver path
   output logic [3:0] min_reception_level_o,
   output logic [3:0] phase_detector_min_level_o,
   output logic receive_input_pin_o,
   output logic low_power_card_detect_o,
   output logic [1:0] signal_source_select_o,
   output logic [3:0] source_onehot_o,
   output logic collision_detect_en_o,
   output logic [1:0] collision_threshold_o,
   output logic [1:0] midrail_trim_o,
   output logic [3:0] highpass_select_o,
   output logic [3:0] gain_select_o
);
   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0] receive_threshold_levels; // Threshold register
   logic [7:0] receiver_input_mode; // Input mode register
   logic [7:0] receiver_analog_tuning; // Analog tuning register
   logic [7:0] next_threshold;
   logic [7:0] next_input_mode;
   logic [7:0] next_analog;
   // Bus answer state
   logic ack; // High in the cycle the access completes
   logic next_ack;
   logic [31:0] next_readdata;
   logic next_waitrequest; // Waitrequest for the next cycle, registered to the pin
   // Field outputs, registered
   logic [3:0] next_min_level;
   logic [3:0] next_phase_level;
   logic next_input_pin;
   logic next_card_detect;
   logic [1:0] next_source;
   logic next_coll_en;
   logic [1:0] next_coll;
   logic [1:0] next_trim;
   logic wr_hit; // Write accepted this cycle

   // ****************************************************************
   // Avalon handshake
   // ****************************************************************
   // Waitrequest is low one cycle after a request arrives; this one cycle
   // of latency lets read data come straight from a flip-flop.
   always_comb begin
      next_ack = (avs_read_i || avs_write_i) && !ack;
      // Waitrequest drops only in the answer cycle; it is held in a flop so
      // the bus sees a clean level straight from a register
      next_waitrequest = !next_ack;
   end

   assign wr_hit = avs_write_i && !ack && avs_byteenable_i[0];

   // Register writes: only byte lane 0 carries data
   always_comb begin
      next_threshold = receive_threshold_levels;
      next_input_mode = receiver_input_mode;
      next_analog = receiver_analog_tuning;
      if (wr_hit) begin
         if (avs_address_i == RXTUN_ADDR_THRESHOLD) begin
            next_threshold = avs_writedata_i[7:0] & RXTUN_MASK_THRESHOLD;
         end else if (avs_address_i == RXTUN_ADDR_INPUT_MODE) begin
            next_input_mode = avs_writedata_i[7:0] & RXTUN_MASK_INPUT_MODE;
         end else if (avs_address_i == RXTUN_ADDR_ANALOG) begin
            next_analog = avs_writedata_i[7:0] & RXTUN_MASK_ANALOG;
         end
      end
   end

   // Read mux; unmapped addresses read zero and complete normally
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (avs_read_i && !ack) begin
         if (avs_address_i == RXTUN_ADDR_THRESHOLD) begin
            next_readdata = {24'h00_0000, receive_threshold_levels};
         end else if (avs_address_i == RXTUN_ADDR_INPUT_MODE) begin
            next_readdata = {24'h00_0000, receiver_input_mode};
         end else if (avs_address_i == RXTUN_ADDR_ANALOG) begin
            next_readdata = {24'h00_0000, receiver_analog_tuning};
         end
      end
   end

   // ****************************************************************
   // Field extraction
   // ****************************************************************
   // Fields follow the stored registers; outputs lag a write by one cycle
   always_comb begin
      next_min_level = receive_threshold_levels[RXTUN_MIN_LEVEL_LSB +: 4];
      next_phase_level = receive_threshold_levels[RXTUN_PHASE_LEVEL_LSB +: 4];
      next_input_pin = receiver_input_mode[RXTUN_INPUT_PIN_BIT];
      next_card_detect = receiver_input_mode[RXTUN_CONV_MODE_BIT];
      next_source = receiver_input_mode[RXTUN_SIG_SRC_LSB +: 2];
      next_coll = receiver_input_mode[RXTUN_COLL_LSB +: 2];
      next_coll_en = (receiver_input_mode[RXTUN_COLL_LSB +: 2] != RXTUN_COLL_OFF);
      // Trim passes through as written; software keeps it zero
      next_trim = receiver_analog_tuning[RXTUN_TRIM_LSB +: 2];
   end

   // Register all state
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         receive_threshold_levels <= RXTUN_RST_THRESHOLD;
         receiver_input_mode <= RXTUN_RST_INPUT_MODE;
         receiver_analog_tuning <= RXTUN_RST_ANALOG;
         ack <= 1'b0;
         avs_waitrequest_o <= 1'b1; // Busy while in reset
         avs_readdata_o <= 32'h0000_0000;
         min_reception_level_o <= 4'h0;
         phase_detector_min_level_o <= 4'h0;
         receive_input_pin_o <= 1'b0;
         low_power_card_detect_o <= 1'b0;
         signal_source_select_o <= 2'h0;
         collision_detect_en_o <= 1'b1;
         collision_threshold_o <= 2'h0;
         midrail_trim_o <= 2'h0;
      end else begin
         receive_threshold_levels <= next_threshold;
         receiver_input_mode <= next_input_mode;
         receiver_analog_tuning <= next_analog;
         ack <= next_ack;
         avs_waitrequest_o <= next_waitrequest;
         avs_readdata_o <= next_readdata;
         min_reception_level_o <= next_min_level;
         phase_detector_min_level_o <= next_phase_level;
         receive_input_pin_o <= next_input_pin;
         low_power_card_detect_o <= next_card_detect;
         signal_source_select_o <= next_source;
         collision_detect_en_o <= next_coll_en;
         collision_threshold_o <= next_coll;
         midrail_trim_o <= next_trim;
      end
   end

   // ****************************************************************
   // One-hot decoders
   // ****************************************************************
   rxtun_onehot u_hpcf (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .code_i(receiver_analog_tuning[RXTUN_HPCF_LSB +: 2]),
      .sel_o(highpass_select_o)
   );

   rxtun_onehot u_gain (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .code_i(receiver_analog_tuning[RXTUN_GAIN_LSB +: 2]),
      .sel_o(gain_select_o)
   );

   rxtun_onehot u_src (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .code_i(receiver_input_mode[RXTUN_SIG_SRC_LSB +: 2]),
      .sel_o(source_onehot_o)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_reserved_mode_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      receiver_input_mode[3:2] == 2'b00)
      else $error("Reserved input mode bits not zero");

   a_reserved_ana_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      receiver_analog_tuning[5:4] == 2'b00)
      else $error("Reserved analog bits not zero");

   a_min_level_out: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_hit && avs_address_i == RXTUN_ADDR_THRESHOLD |=> ##1
      min_reception_level_o == $past(avs_writedata_i[7:4], 2))
      else $error("Reception level output wrong");

   a_phase_level_out: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_hit && avs_address_i == RXTUN_ADDR_THRESHOLD |=> ##1
      phase_detector_min_level_o == $past(avs_writedata_i[3:0], 2))
      else $error("Phase level output wrong");

   a_input_pin_out: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 receive_input_pin_o == $past(receiver_input_mode[7]))
      else $error("Input pin mode wrong");

   a_card_detect_out: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 low_power_card_detect_o == $past(receiver_input_mode[6]))
      else $error("Converter mode wrong");

   a_source_onehot: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 source_onehot_o[signal_source_select_o] && $onehot(source_onehot_o))
      else $error("Source select mismatch");

   a_coll_off: assert property (@(posedge clk_i) disable iff (reset_i)
      collision_detect_en_o == (collision_threshold_o != 2'b11))
      else $error("Collision enable mismatch");

   a_hpcf_sel: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 highpass_select_o == (4'h1 << $past(receiver_analog_tuning[3:2])))
      else $error("High-pass select wrong");

   a_gain_sel: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 gain_select_o == (4'h1 << $past(receiver_analog_tuning[1:0])))
      else $error("Gain select wrong");

   a_bus_answer: assert property (@(posedge clk_i) disable iff (reset_i)
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("Bus answer late");

   // The answer lasts one cycle; a master that holds its request past it
   // sees a second acknowledge for the same transfer two cycles later
   a_wait_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("Waitrequest low too long");

   // Upper byte lanes never carry register data
   a_read_upper_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      avs_readdata_o[31:8] == 24'h00_0000)
      else $error("Upper read lanes not zero");

   // ****************************************************************
   // Write and read paths
   // ****************************************************************
   // A write lands at the edge that first sees it
   a_thr_write_lands: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_hit && avs_address_i == RXTUN_ADDR_THRESHOLD |=>
      receive_threshold_levels == $past(avs_writedata_i[7:0]))
      else $error("Threshold write lost");

   // Only the defined input mode fields take the written bits
   a_mode_write_lands: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_hit && avs_address_i == RXTUN_ADDR_INPUT_MODE |=>
      receiver_input_mode[7:4] == $past(avs_writedata_i[7:4]) &&
      receiver_input_mode[1:0] == $past(avs_writedata_i[1:0]))
      else $error("Input mode write lost");

   a_ana_write_lands: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_hit && avs_address_i == RXTUN_ADDR_ANALOG |=>
      receiver_analog_tuning[7:6] == $past(avs_writedata_i[7:6]) &&
      receiver_analog_tuning[3:0] == $past(avs_writedata_i[3:0]))
      else $error("Analog write lost");

   // A write with lane 0 off must leave every register alone
   a_lane_off_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
      avs_write_i && !ack && !avs_byteenable_i[0] |=>
      $stable(receive_threshold_levels) && $stable(receiver_input_mode) && $stable(receiver_analog_tuning))
      else $error("Write with lane 0 off landed");

   // Unmapped writes fall through the decode without effect
   a_unmapped_write: assert property (@(posedge clk_i) disable iff (reset_i)
      avs_write_i && !ack && avs_address_i != RXTUN_ADDR_THRESHOLD &&
      avs_address_i != RXTUN_ADDR_INPUT_MODE && avs_address_i != RXTUN_ADDR_ANALOG |=>
      $stable(receive_threshold_levels) && $stable(receiver_input_mode) && $stable(receiver_analog_tuning))
      else $error("Unmapped write landed");

   // Read data come from the register as it stood at the request edge
   a_read_threshold: assert property (@(posedge clk_i) disable iff (reset_i)
      avs_read_i && !ack && avs_address_i == RXTUN_ADDR_THRESHOLD |=>
      avs_readdata_o == {24'h00_0000, $past(receive_threshold_levels)})
      else $error("Threshold read wrong");

   a_read_unmapped: assert property (@(posedge clk_i) disable iff (reset_i)
      avs_read_i && !ack && avs_address_i != RXTUN_ADDR_THRESHOLD &&
      avs_address_i != RXTUN_ADDR_INPUT_MODE && avs_address_i != RXTUN_ADDR_ANALOG |=>
      avs_readdata_o == 32'h0000_0000)
      else $error("Unmapped read not zero");

   // ****************************************************************
   // Remaining field outputs
   // ****************************************************************
   a_source_code_out: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 signal_source_select_o == $past(receiver_input_mode[5:4]))
      else $error("Source code output wrong");

   a_coll_code_out: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 collision_threshold_o == $past(receiver_input_mode[1:0]))
      else $error("Collision code output wrong");

   // Trim is passed on untouched; keeping it zero is software's duty
   a_trim_out: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 midrail_trim_o == $past(receiver_analog_tuning[7:6]))
      else $error("Trim output wrong");
endmodule : rxtun_regs
